/* File: design/scsc_defines.vh */
/*
 constants for the system clock source selector: configuration word 2 field
 positions, erased values, source and mode encodings.
 assumes nothing beyond being included once per compile unit.
*/
`ifndef SCSC_DEFINES_VH
`define SCSC_DEFINES_VH

`define SCSC_CFG_W 16
`define SCSC_PDM_LO 0
`define SCSC_PDM_HI 1
`define SCSC_CSM_LO 6
`define SCSC_CSM_HI 7
`define SCSC_IOC_LO 8
`define SCSC_IOC_HI 10

`define SCSC_PDM_EXT 2'h0
`define SCSC_PDM_STD 2'h1
`define SCSC_PDM_HS 2'h2
`define SCSC_PDM_OFF 2'h3

`define SCSC_IOC_FRC 3'h0
`define SCSC_IOC_FAST_RC_WITH_PLL 3'h1
`define SCSC_IOC_PRI 3'h2
`define SCSC_IOC_PRIPLL 3'h3
`define SCSC_IOC_SEC 3'h4
`define SCSC_IOC_LOW_POWER_INTERNAL_RC 3'h5
`define SCSC_IOC_RSVD 3'h6
`define SCSC_IOC_FAST_RC_WITH_DIVIDER 3'h7

`define SCSC_CSM_FULL_ON 2'h0

// source select, one-hot: primary, secondary, fast rc, low power rc
`define SCSC_SRC_W 4
`define SCSC_SRC_PRI 4'h1
`define SCSC_SRC_SEC 4'h2
`define SCSC_SRC_FRC 4'h4
`define SCSC_SRC_LOW_POWER_INTERNAL_RC 4'h8

// primary type, one-hot: external clock, standard crystal, high-speed crystal
`define SCSC_PT_W 3
`define SCSC_PT_NONE 3'h0
`define SCSC_PT_EXT 3'h1
`define SCSC_PT_STD 3'h2
`define SCSC_PT_HS 3'h4

`define SCSC_PLL_MHZ 96
`define SCSC_FRC_MHZ 8
`define SCSC_DIV_W 3
`define SCSC_DIV_RST 3'h0

`endif

/* File: design/scsc_top.v */
/*
 system clock source selector: latches configuration word 2 at power-on,
 decodes the source, primary type, pll use, divider use, switch and monitor
 enables, and makes the instruction cycle clock enable (fosc/2).
 assumes CFG_WORD2 is stable while RESETN is low and the first cycles after;
 RESETN low is a power-on reset. clocks are modelled as selects and enables.
*/
// Functional notes
// - system clock comes from exactly one of four sources.
// - primary or fast rc through pll gives usb clock and system clock.
// - fast rc runs at 8 MHz, programmable divider may reduce it.
// - instruction cycle clock is processor clock divided by two.
// - some primary modes put instruction cycle clock on oscillator output pin.
// - at power-on source comes from word 2 bits 1:0 and 10:8.
// - erased device starts in fast rc with divider, codes 11 and 111.
// - clock switching allowed only when upper switch/monitor bit is zero.
// - fail-safe clock monitor enabled only when both bits are zero.
// - with mode 11, 101 low power rc, 100 secondary, 110 reserved.
// - 011 primary with pll, 010 without; mode gives primary type.
// - with mode 11, 001 fast rc with pll, 000 plain fast rc.
// - internal and secondary modes take pin function from configuration bit.
`timescale 1ns/1ps
`default_nettype none
`include "scsc_defines.vh"

module scsc_top #(
  parameter DIV_W = `SCSC_DIV_W
) (
  input wire CLK,
  input wire RESETN,
  input wire [`SCSC_CFG_W-1:0] CFG_WORD2,
  input wire OSC_OUT_PIN_FUNCTION,
  input wire SWITCH_REQ,
  input wire [`SCSC_SRC_W-1:0] SWITCH_SRC,
  input wire [DIV_W-1:0] FRC_DIV_SEL,
  output reg [`SCSC_SRC_W-1:0] SYS_SRC,
  output reg [`SCSC_PT_W-1:0] PRIMARY_TYPE,
  output reg PLL_EN,
  output reg USB_CLK_EN,
  output reg FRC_DIV_EN,
  output reg [DIV_W-1:0] FRC_DIV,
  output reg CLK_SWITCH_EN,
  output reg FAILSAFE_MON_EN,
  output reg CFG_RESERVED,
  output reg INSTR_CLK_EN,
  output reg OSC_OUT_IS_FCY,
  output reg OSC_OUT_IS_GPIO
);

  reg loaded;
  reg [`SCSC_CFG_W-1:0] cfg;
  reg fcy_phase;
  reg [`SCSC_SRC_W-1:0] next_src;
  reg [`SCSC_PT_W-1:0] next_pt;
  reg next_pll;
  reg next_div;
  reg next_rsvd;
  wire [1:0] pdm;
  wire [2:0] ioc;
  wire [1:0] csm;
  wire sw_en;
  wire mon_en;
  wire src_onehot;

  assign pdm = cfg[`SCSC_PDM_HI:`SCSC_PDM_LO];
  assign ioc = cfg[`SCSC_IOC_HI:`SCSC_IOC_LO];
  assign csm = cfg[`SCSC_CSM_HI:`SCSC_CSM_LO];
  assign sw_en = ~csm[1];
  assign mon_en = (csm == `SCSC_CSM_FULL_ON);
  assign src_onehot = (SWITCH_SRC == `SCSC_SRC_PRI) || (SWITCH_SRC == `SCSC_SRC_SEC) ||
    (SWITCH_SRC == `SCSC_SRC_FRC) || (SWITCH_SRC == `SCSC_SRC_LOW_POWER_INTERNAL_RC);

  // decode of the power-on configuration
  always @* begin
    next_src = `SCSC_SRC_FRC;
    next_pt = `SCSC_PT_NONE;
    next_pll = 1'b0;
    next_div = 1'b0;
    next_rsvd = 1'b0;
    case (ioc)
      `SCSC_IOC_FAST_RC_WITH_DIVIDER: begin
        next_div = 1'b1;
      end
      `SCSC_IOC_LOW_POWER_INTERNAL_RC: begin
        next_src = `SCSC_SRC_LOW_POWER_INTERNAL_RC;
      end
      `SCSC_IOC_SEC: begin
        next_src = `SCSC_SRC_SEC;
      end
      `SCSC_IOC_PRIPLL, `SCSC_IOC_PRI: begin
        next_src = `SCSC_SRC_PRI;
        next_pll = (ioc == `SCSC_IOC_PRIPLL);
        case (pdm)
          `SCSC_PDM_EXT: next_pt = `SCSC_PT_EXT;
          `SCSC_PDM_STD: next_pt = `SCSC_PT_STD;
          `SCSC_PDM_HS: begin
            next_pt = `SCSC_PT_HS;
            next_pll = 1'b0; // high-speed crystal has no pll mode
            next_rsvd = (ioc == `SCSC_IOC_PRIPLL);
          end
          default: next_rsvd = 1'b1;
        endcase
      end
      `SCSC_IOC_FAST_RC_WITH_PLL: begin
        next_pll = 1'b1;
      end
      `SCSC_IOC_FRC: begin
        next_src = `SCSC_SRC_FRC;
      end
      default: begin
        next_rsvd = 1'b1; // reserved code falls back to fast rc
      end
    endcase
  end

  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      loaded <= 1'b0;
      cfg <= {`SCSC_CFG_W{1'b1}}; // erased state
      SYS_SRC <= `SCSC_SRC_FRC;
      PRIMARY_TYPE <= `SCSC_PT_NONE;
      PLL_EN <= 1'b0;
      USB_CLK_EN <= 1'b0;
      FRC_DIV_EN <= 1'b1;
      FRC_DIV <= `SCSC_DIV_RST;
      CLK_SWITCH_EN <= 1'b0;
      FAILSAFE_MON_EN <= 1'b0;
      CFG_RESERVED <= 1'b0;
      fcy_phase <= 1'b0;
      INSTR_CLK_EN <= 1'b0;
      OSC_OUT_IS_FCY <= 1'b0;
      OSC_OUT_IS_GPIO <= 1'b0;
    end else begin
      loaded <= 1'b1;
      if (!loaded) begin
        cfg <= CFG_WORD2; // captured once after release
      end else begin
        // exactly one source: the decoded one, or SWITCH_SRC while an allowed request is held
        SYS_SRC <= next_src;
        PRIMARY_TYPE <= next_pt;
        PLL_EN <= next_pll;
        USB_CLK_EN <= next_pll;
        FRC_DIV_EN <= next_div;
        CFG_RESERVED <= next_rsvd;
        CLK_SWITCH_EN <= sw_en;
        FAILSAFE_MON_EN <= mon_en;
        if (CLK_SWITCH_EN && SWITCH_REQ && src_onehot) begin
          SYS_SRC <= SWITCH_SRC;
          PLL_EN <= 1'b0;
          USB_CLK_EN <= 1'b0; // no pll after a switch
          FRC_DIV_EN <= (SWITCH_SRC == `SCSC_SRC_FRC);
        end
        if (CLK_SWITCH_EN) begin
          cfg <= cfg;
        end
      end
      if (FRC_DIV_EN) begin
        FRC_DIV <= FRC_DIV_SEL;
      end else begin
        FRC_DIV <= `SCSC_DIV_RST;
      end
      fcy_phase <= ~fcy_phase;
      INSTR_CLK_EN <= fcy_phase;
      OSC_OUT_IS_FCY <= (SYS_SRC == `SCSC_SRC_PRI) && (PRIMARY_TYPE == `SCSC_PT_EXT);
      OSC_OUT_IS_GPIO <= (SYS_SRC != `SCSC_SRC_PRI) && OSC_OUT_PIN_FUNCTION;
    end
  end

endmodule
`default_nettype wire

/* File: verif/scsc_nvm.sv */
/* configuration store model feeding word 2
 assumes erased reads as all ones */
`timescale 1ns/1ps
`default_nettype none
module scsc_nvm (
  input wire logic [15:0] prog,
  input wire logic erased,
  output logic [15:0] word
);
  assign word = erased ? 16'hffff : prog;
endmodule
`default_nettype wire

/* File: verif/scsc_monitor.sv */
/* port checker for scsc_top
 assumes config stable after reset */
`timescale 1ns/1ps
`default_nettype none
module scsc_monitor (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [15:0] CFG_WORD2,
  input wire logic SWITCH_REQ,
  input wire logic [3:0] SWITCH_SRC,
  input wire logic [3:0] SYS_SRC,
  input wire logic PLL_EN,
  input wire logic USB_CLK_EN,
  input wire logic CLK_SWITCH_EN,
  input wire logic FAILSAFE_MON_EN,
  input wire logic INSTR_CLK_EN
);
  logic [1:0] up;
  wire ok = up[1];
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  one_src_a: assert property (ok |-> $onehot(SYS_SRC)) else $error("src");
  usb_pll_a: assert property (ok |-> USB_CLK_EN == PLL_EN) else $error("usb");
  fcy_div_a: assert property (ok |-> INSTR_CLK_EN != $past(INSTR_CLK_EN)) else $error("fcy");
  erased_src_a: assert property (ok && CFG_WORD2[10:8] == 3'h7 && CFG_WORD2[1:0] == 2'h3
    && !$past(SWITCH_REQ) |-> SYS_SRC == 4'h4) else $error("erased");
  sw_en_a: assert property (ok |-> CLK_SWITCH_EN == !CFG_WORD2[7]) else $error("sw");
  sw_go_a: assert property (&up && CLK_SWITCH_EN && SWITCH_REQ && $onehot(SWITCH_SRC)
    |=> SYS_SRC == $past(SWITCH_SRC)) else $error("go");
  mon_en_a: assert property (ok |-> FAILSAFE_MON_EN == (CFG_WORD2[7:6] == 2'h0)) else $error("mon");
  src_hold_a: assert property (&up && CFG_WORD2[7] |-> $stable(SYS_SRC)) else $error("hold");
  cover property (CLK_SWITCH_EN && SWITCH_REQ);
  cover property (PLL_EN);
  cover property (FAILSAFE_MON_EN);
endmodule
bind scsc_top scsc_monitor i_mon (.CLK, .RESETN, .CFG_WORD2, .SWITCH_REQ, .SWITCH_SRC,
  .SYS_SRC, .PLL_EN, .USB_CLK_EN, .CLK_SWITCH_EN, .FAILSAFE_MON_EN, .INSTR_CLK_EN);
`default_nettype wire

/* File: verif/scsc_top_tb.sv */
/* bench for scsc_top: power-on decode and switching
 assumes design sources compiled first */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
  $display("Error t=%0t got %h exp %h", $time, a, e); end end
module scsc_top_tb;
  logic CLK = 0, RESETN = 0, SWITCH_REQ = 0, ers = 0, opf = 1;
  logic [15:0] prog = 16'h0, CFG_WORD2;
  logic [3:0] SWITCH_SRC = 4'h8, SYS_SRC;
  logic [2:0] PRIMARY_TYPE, FRC_DIV;
  logic PLL_EN, USB_CLK_EN, FRC_DIV_EN, CLK_SWITCH_EN, FAILSAFE_MON_EN, CFG_RESERVED;
  logic INSTR_CLK_EN, OSC_OUT_IS_FCY, OSC_OUT_IS_GPIO;
  int mismatches = 0, checks_done = 0;
  logic [15:0] cfg [11] = '{16'h0000, 16'h0503, 16'h04c3, 16'h0301, 16'h0300, 16'h0202,
    16'h0201, 16'h0200, 16'h01c3, 16'h0003, 16'h06c3};
  logic [8:0] want [11] = '{9'h080, 9'h100, 9'h040, 9'h034, 9'h032, 9'h028, 9'h024,
    9'h022, 9'h090, 9'h080, 9'h081};
  always #5 CLK = ~CLK;
  scsc_nvm i_nvm (.prog, .erased(ers), .word(CFG_WORD2));
  scsc_top i_dut (.CLK, .RESETN, .CFG_WORD2, .OSC_OUT_PIN_FUNCTION(opf), .SWITCH_REQ,
    .SWITCH_SRC, .FRC_DIV_SEL(3'h5), .SYS_SRC, .PRIMARY_TYPE, .PLL_EN, .USB_CLK_EN,
    .FRC_DIV_EN, .FRC_DIV, .CLK_SWITCH_EN, .FAILSAFE_MON_EN, .CFG_RESERVED,
    .INSTR_CLK_EN, .OSC_OUT_IS_FCY, .OSC_OUT_IS_GPIO);
  task por(input logic [15:0] c, input logic e);
    @(negedge CLK);
    RESETN = 0;
    prog = c;
    ers = e;
    repeat (2) @(negedge CLK);
    RESETN = 1;
    repeat (3) @(negedge CLK);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 11; i++) begin
      opf = (i % 3) != 1;
      por(cfg[i], i == 0);
      `CHK({SYS_SRC, PLL_EN, PRIMARY_TYPE, CFG_RESERVED}, want[i])
      `CHK(USB_CLK_EN, want[i][4])
      `CHK({FRC_DIV_EN, FRC_DIV}, i == 0 ? 4'hd : 4'h0)
      `CHK({OSC_OUT_IS_FCY, OSC_OUT_IS_GPIO}, {want[i][3:1] == 3'h1, want[i][8:5] != 4'h1 && opf})
      `CHK({CLK_SWITCH_EN, FAILSAFE_MON_EN}, {!CFG_WORD2[7], CFG_WORD2[7:6] == 2'h0})
    end
    for (int j = 0; j < 2; j++) begin
      por(j ? 16'h0083 : 16'h0003, 1'b0);
      SWITCH_REQ = 1;
      repeat (2) @(negedge CLK);
      `CHK(SYS_SRC, j ? 4'h4 : 4'h8)
      SWITCH_REQ = 0;
    end
    test_done;
  end
  initial begin
    #50000;
    mismatches++;
    test_done;
  end
endmodule
`default_nettype wire
